// >>> hdl/adc_host_pkg.sv
package adc_host_pkg;

  localparam int CH_COUNT = 6;
  localparam int WORD_W   = 16;
  localparam int BANK_W   = CH_COUNT * WORD_W;
  localparam int LINE_CNT = 3;
  localparam int PTR_W    = 3;
  localparam int CNT_W    = 7;

  // apb register byte offsets
  localparam logic [7:0] OFF_CONV_TIME = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_RESULT0   = 8'h08;
  localparam logic [7:0] OFF_RESULT5   = 8'h1C;

  // status register fields
  localparam int ST_BUSY     = 0;
  localparam int ST_SERIAL   = 1;
  localparam int ST_REF_EN   = 2;
  localparam int ST_HW_SW    = 3;
  localparam int ST_PTR_LSB  = 4;
  localparam int ST_CTRL_LSB = 8;

  // reset values and counts
  localparam logic [15:0] CONV_TIME_RESET = 16'h0064;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  localparam logic [7:0]  CTRL_BYTE_RESET = 8'h00;
  localparam logic [2:0]  PTR_LAST        = 3'h5;
  localparam logic        REF_EN_RESET    = 1'b1;

  typedef enum logic [0:0] {
    CONV_IDLE = 1'b0,
    CONV_RUN  = 1'b1
  } conv_state_e;

  // pin group that enters the pclk domain through the synchroniser
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_ref;
    logic       hw_sw;
    logic       ser_par;
    logic [2:0] start;
  } pin_ctrl_s;

  // idle levels of the pin group; the synchroniser resets to these
  localparam pin_ctrl_s PIN_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_ref: 1'b1, default: '0};

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } apb_req_s;

endpackage

// >>> hdl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser; stage one is read by stage two only
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = meta_reg;
    q_next    = q;
    if (en) begin
      meta_next = d;
      q_next    = meta_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end

endmodule // pin_sync

`default_nettype wire

// >>> hdl/serial_shifter.sv
`timescale 1ns/10ps
`default_nettype none

// runs on the host serial clock; frame held in reset while select is high
module serial_shifter (
  input  wire logic                             serial_clk,
  input  wire logic                             frame_rst_n,
  input  wire logic [adc_host_pkg::BANK_W-1:0]  bank,
  input  wire logic [2:0]                       line_sel,
  output var  logic [adc_host_pkg::LINE_CNT-1:0] dout,
  output var  logic [adc_host_pkg::LINE_CNT-1:0] dout_oe
);

  logic [adc_host_pkg::CNT_W-1:0]    cnt_reg;
  logic [adc_host_pkg::CNT_W-1:0]    cnt_next;
  logic [adc_host_pkg::LINE_CNT-1:0] dout_next;
  logic [adc_host_pkg::LINE_CNT-1:0] oe_next;
  logic [adc_host_pkg::CNT_W-1:0]    len;

  function automatic logic [adc_host_pkg::CNT_W-1:0] word_len(input logic [2:0] sel);
    if (sel[2])
      word_len = 7'd32;
    else if (sel[1])
      word_len = 7'd48;
    else
      word_len = 7'd96;
  endfunction

  function automatic logic bank_bit(input logic [adc_host_pkg::BANK_W-1:0] b,
                                    input logic [adc_host_pkg::CNT_W-1:0] base,
                                    input logic [adc_host_pkg::CNT_W-1:0] cnt);
    logic [adc_host_pkg::CNT_W-1:0] pos;
    pos      = 7'(base + cnt);
    bank_bit = b[7'(7'd95 - pos)];
  endfunction

  always_comb begin
    len       = word_len(line_sel);
    cnt_next  = cnt_reg;
    dout_next = '0;
    oe_next   = '0;
    // msb first; line a carries the first channels, b and c the later ones
    oe_next[0] = line_sel[0];
    oe_next[1] = line_sel[1];
    oe_next[2] = line_sel[2];
    if (cnt_reg < len) begin
      dout_next[0] = line_sel[0] & bank_bit(bank, 7'd0, cnt_reg);
      dout_next[1] = line_sel[1] & bank_bit(bank, len, cnt_reg);
      dout_next[2] = line_sel[2] & bank_bit(bank, 7'(len + len), cnt_reg);
      cnt_next     = 7'(cnt_reg + 7'd1);
    end
  end

  always_ff @(posedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_reg <= '0;
      dout    <= '0;
      dout_oe <= '0;
    end else begin
      cnt_reg <= cnt_next;
      dout    <= dout_next;
      dout_oe <= oe_next;
    end
  end

endmodule // serial_shifter

`default_nettype wire

// >>> hdl/adc_host_interface_select.sv
// Notes on behaviour
// - parallel mode, select and read low: drive result onto the data lines
// - parallel mode, select and write low: upper data byte loads control register
// - write/reference pin is write strobe only in hardware-select high
// - hardware-select low: reference pin 0 disables, 1 enables internal reference
// - serial mode: falling select frames transfer, msb presented first
// - busy rises at conversion start, falls on the same edge that latches the result
// - serial/parallel select low picks parallel, high picks serial
// - serial mode: lines 10..8 outputs c..a, 0..2 selects, 7 chain enable
// - parallel mode: select-shared pins are three-state data outputs
// - select-a at 1 enables output a; host always holds it at 1
// - select-b 1 enables output b; at 0 b is no data output
// - select-c 1 enables output c; at 0 c is no data output
// - rising pair start puts pair into hold and begins conversion
`timescale 1ns/10ps
`default_nettype none

module adc_host_interface_select (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        serial_clk,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        write_or_ref_control_pin,
  input  wire logic        hw_sw_select,
  input  wire logic        serial_parallel_select,
  input  wire logic [2:0]  pair_sample_start,
  input  wire logic [15:0] parallel_data_line_in,
  output var  logic [15:0] parallel_data_line_out,
  output var  logic [15:0] parallel_data_line_oe,
  output var  logic [2:0]  serial_data_out,
  output var  logic [2:0]  serial_data_oe,
  output var  logic        busy,
  output var  logic        internal_ref_enable,
  output var  logic        chain_mode_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  adc_host_pkg::pin_ctrl_s pins_raw;
  adc_host_pkg::pin_ctrl_s pins;
  adc_host_pkg::pin_ctrl_s pins_q;
  logic [15:0]             data_in_s;

  assign pins_raw = '{cs_n: cs_n, rd_n: rd_n, wr_ref: write_or_ref_control_pin,
                      hw_sw: hw_sw_select, ser_par: serial_parallel_select,
                      start: pair_sample_start};

  // active-low pins cross inverted so the flops reset to their idle level;
  // otherwise a false read strobe and pointer step would follow reset
  pin_sync #(.W($bits(adc_host_pkg::pin_ctrl_s))) u_ctrl_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (clk_en),
    .d     (pins_raw ^ adc_host_pkg::PIN_IDLE),
    .q     (pins_q)
  );

  assign pins = pins_q ^ adc_host_pkg::PIN_IDLE;

  pin_sync #(.W(16)) u_data_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (clk_en),
    .d     (parallel_data_line_in),
    .q     (data_in_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  adc_host_pkg::conv_state_e      conv_reg;
  adc_host_pkg::conv_state_e      conv_next;
  logic [15:0]                    conv_cnt_reg;
  logic [15:0]                    conv_cnt_next;
  logic [15:0]                    conv_time_reg;
  logic [15:0]                    conv_time_next;
  logic [2:0]                     start_prev_reg;
  logic [2:0]                     start_prev_next;
  logic [2:0]                     pair_hold_reg;
  logic [2:0]                     pair_hold_next;
  logic [15:0]                    pend_reg [adc_host_pkg::CH_COUNT];
  logic [15:0]                    pend_next [adc_host_pkg::CH_COUNT];
  logic [adc_host_pkg::BANK_W-1:0] bank_reg;
  logic [adc_host_pkg::BANK_W-1:0] bank_next;
  logic [adc_host_pkg::PTR_W-1:0] ptr_reg;
  logic [adc_host_pkg::PTR_W-1:0] ptr_next;
  logic                           rd_act_reg;
  logic                           rd_act_next;
  logic                           wr_act_reg;
  logic                           wr_act_next;
  logic [7:0]                     ctrl_byte_reg;
  logic [7:0]                     ctrl_byte_next;
  logic [7:0]                     wr_byte_reg;
  logic [7:0]                     wr_byte_next;
  logic                           busy_next;
  logic                           ref_en_next;
  logic                           chain_next;
  logic [15:0]                    pout_next;
  logic [15:0]                    poe_next;
  logic [31:0]                    prdata_next;
  logic                           pready_next;
  logic                           pslverr_next;
  adc_host_pkg::apb_req_s         req;
  logic                           rd_now;
  logic                           wr_now;
  logic                           serial_mode;
  logic [2:0]                     rise;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  function automatic logic is_result(input logic [7:0] a);
    is_result = (a >= adc_host_pkg::OFF_RESULT0) && (a <= adc_host_pkg::OFF_RESULT5) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] result_idx(input logic [7:0] a);
    logic [7:0] d;
    d          = 8'(a - adc_host_pkg::OFF_RESULT0);
    result_idx = d[4:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode, strobes and conversion

  always_comb begin
    serial_mode = pins.ser_par;
    rd_now      = !serial_mode && !pins.cs_n && !pins.rd_n;
    // wr/ref pin is a write strobe only with hardware-select high
    wr_now      = !serial_mode && pins.hw_sw && !pins.cs_n && !pins.wr_ref;
    rise        = pins.start & ~start_prev_reg;

    start_prev_next = pins.start;
    conv_next       = conv_reg;
    conv_cnt_next   = conv_cnt_reg;
    pair_hold_next  = pair_hold_reg;
    bank_next       = bank_reg;
    busy_next       = busy;
    ptr_next        = ptr_reg;
    rd_act_next     = rd_now;
    wr_act_next     = wr_now;
    wr_byte_next    = wr_byte_reg;
    ctrl_byte_next  = ctrl_byte_reg;
    ref_en_next     = internal_ref_enable;
    chain_next      = serial_mode & data_in_s[7];

    case (conv_reg)
      adc_host_pkg::CONV_IDLE: begin
        // starts during busy are ignored, the host must not issue them
        if (rise != 3'b000) begin
          conv_next      = adc_host_pkg::CONV_RUN;
          conv_cnt_next  = conv_time_reg;
          pair_hold_next = rise;
          busy_next      = 1'b1;
          ptr_next       = '0;
        end
      end
      adc_host_pkg::CONV_RUN: begin
        if (conv_cnt_reg <= 16'h0001) begin
          conv_next = adc_host_pkg::CONV_IDLE;
          busy_next = 1'b0;
          for (int p = 0; p < 3; p++) begin
            if (pair_hold_reg[p]) begin
              bank_next[95 - 32*p -: 16] = pend_reg[2*p];
              bank_next[79 - 32*p -: 16] = pend_reg[2*p + 1];
            end
          end
        end else begin
          conv_cnt_next = 16'(conv_cnt_reg - 16'h0001);
        end
      end
      default: begin
        conv_next = adc_host_pkg::CONV_IDLE;
        busy_next = 1'b0;
      end
    endcase

    // each finished parallel read steps to the next channel
    if (rd_act_reg && !rd_now)
      ptr_next = (ptr_reg == adc_host_pkg::PTR_LAST) ? '0 : 3'(ptr_reg + 3'h1);

    // upper byte sampled while the strobe is low, committed at its release
    if (wr_now)
      wr_byte_next = data_in_s[15:8];
    if (wr_act_reg && !wr_now)
      ctrl_byte_next = wr_byte_reg;

    if (!pins.hw_sw)
      ref_en_next = pins.wr_ref;

    pout_next = bank_reg[8'(8'd95 - 8'(ptr_reg) * 8'd16) -: 16];
    poe_next  = rd_now ? 16'hFFFF : 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_reg               <= adc_host_pkg::CONV_IDLE;
      conv_cnt_reg           <= '0;
      start_prev_reg         <= '0;
      pair_hold_reg          <= '0;
      bank_reg               <= '0;
      ptr_reg                <= '0;
      rd_act_reg             <= 1'b0;
      wr_act_reg             <= 1'b0;
      wr_byte_reg            <= adc_host_pkg::CTRL_BYTE_RESET;
      ctrl_byte_reg          <= adc_host_pkg::CTRL_BYTE_RESET;
      busy                   <= 1'b0;
      internal_ref_enable    <= adc_host_pkg::REF_EN_RESET;
      chain_mode_enable      <= 1'b0;
      parallel_data_line_out <= '0;
      parallel_data_line_oe  <= '0;
    end else if (clk_en) begin
      conv_reg               <= conv_next;
      conv_cnt_reg           <= conv_cnt_next;
      start_prev_reg         <= start_prev_next;
      pair_hold_reg          <= pair_hold_next;
      bank_reg               <= bank_next;
      ptr_reg                <= ptr_next;
      rd_act_reg             <= rd_act_next;
      wr_act_reg             <= wr_act_next;
      wr_byte_reg            <= wr_byte_next;
      ctrl_byte_reg          <= ctrl_byte_next;
      busy                   <= busy_next;
      internal_ref_enable    <= ref_en_next;
      chain_mode_enable      <= chain_next;
      parallel_data_line_out <= pout_next;
      parallel_data_line_oe  <= poe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, pslverr on unmapped offsets

  always_comb begin
    conv_time_next = conv_time_reg;
    for (int i = 0; i < adc_host_pkg::CH_COUNT; i++)
      pend_next[i] = pend_reg[i];
    prdata_next  = '0;
    pslverr_next = 1'b0;
    pready_next  = req.sel && req.enable && !pready;
    // a write lands at the edge where the master samples pready high
    if (pready && req.sel && req.enable && req.write) begin
      if (req.addr == adc_host_pkg::OFF_CONV_TIME)
        conv_time_next = req.wdata[15:0];
      else if (is_result(req.addr))
        pend_next[result_idx(req.addr)] = req.wdata[15:0];
    end
    if (pready_next) begin
      if (req.addr == adc_host_pkg::OFF_CONV_TIME) begin
        prdata_next = {16'h0000, conv_time_reg};
      end else if (req.addr == adc_host_pkg::OFF_STATUS) begin
        prdata_next[adc_host_pkg::ST_BUSY]                          = busy;
        prdata_next[adc_host_pkg::ST_SERIAL]                        = serial_mode;
        prdata_next[adc_host_pkg::ST_REF_EN]                        = internal_ref_enable;
        prdata_next[adc_host_pkg::ST_HW_SW]                         = pins.hw_sw;
        prdata_next[adc_host_pkg::ST_PTR_LSB +: 3]                  = ptr_reg;
        prdata_next[adc_host_pkg::ST_CTRL_LSB +: 8]                 = ctrl_byte_reg;
      end else if (is_result(req.addr)) begin
        prdata_next = {16'h0000, pend_reg[result_idx(req.addr)]};
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_time_reg <= adc_host_pkg::CONV_TIME_RESET;
      for (int i = 0; i < adc_host_pkg::CH_COUNT; i++)
        pend_reg[i] <= adc_host_pkg::RESULT_RESET;
      prdata        <= '0;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
    end else if (clk_en) begin
      conv_time_reg <= conv_time_next;
      for (int i = 0; i < adc_host_pkg::CH_COUNT; i++)
        pend_reg[i] <= pend_next[i];
      prdata        <= prdata_next;
      pready        <= pready_next;
      pslverr       <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial link on the host clock
  // the bank only changes at the end of a conversion; a frame read while
  // busy is low sees a quiet word, so no per-bit crossing is needed

  logic frame_rst_n;

  // frame reset from the select pin; read strobe assumed low in serial mode
  assign frame_rst_n = presetn & serial_parallel_select & ~cs_n;

  serial_shifter u_serial (
    .serial_clk  (serial_clk),
    .frame_rst_n (frame_rst_n),
    .bank        (bank_reg),
    .line_sel    (parallel_data_line_in[2:0]),
    .dout        (serial_data_out),
    .dout_oe     (serial_data_oe)
  );

endmodule // adc_host_interface_select

`default_nettype wire

// >>> verification/adc_host_interface_select_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module adc_host_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        write_or_ref_control_pin,
  input wire logic        hw_sw_select,
  input wire logic        serial_parallel_select,
  input wire logic [2:0]  pair_sample_start,
  input wire logic [15:0] parallel_data_line_in,
  input wire logic [15:0] parallel_data_line_oe,
  input wire logic [2:0]  serial_data_oe,
  input wire logic        busy,
  input wire logic        internal_ref_enable,
  input wire logic        chain_mode_enable
);
  wire        ser = serial_parallel_select;
  wire [15:0] ln  = parallel_data_line_in;
  wire [15:0] oe  = parallel_data_line_oe;
  wire        wr  = write_or_ref_control_pin;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // pins reach pclk logic three edges late, so level rules wait four
  property p_rd_on; (!cs_n && !rd_n && !ser && clk_en)[*4] |-> oe == 16'hffff; endproperty
  a_rd_on: assert property (p_rd_on) else $error("bus not driven on read");
  property p_rd_off; ((cs_n || rd_n) && clk_en)[*4] |-> oe == 16'h0000; endproperty
  a_rd_off: assert property (p_rd_off) else $error("bus driven while idle");
  property p_ser_bus; (ser && clk_en)[*4] |-> oe == 16'h0000; endproperty
  a_ser_bus: assert property (p_ser_bus) else $error("bus driven in serial mode");
  property p_sout_off; cs_n || !ser |-> serial_data_oe == 3'b000; endproperty
  a_sout_off: assert property (p_sout_off) else $error("serial out outside frame");
  property p_sel_b; (!ln[1])[*8] |-> !serial_data_oe[1]; endproperty
  a_sel_b: assert property (p_sel_b) else $error("line b on while deselected");
  property p_sel_c; (!ln[2])[*8] |-> !serial_data_oe[2]; endproperty
  a_sel_c: assert property (p_sel_c) else $error("line c on while deselected");
  property p_start; !busy && $rose(|pair_sample_start) && clk_en |-> ##[2:6] busy; endproperty
  a_start: assert property (p_start) else $error("start gave no busy");
  property p_busy; $rose(busy) |-> ##[1:300] !busy; endproperty
  a_busy: assert property (p_busy) else $error("busy never ends");
  property p_ref;
    (!hw_sw_select && clk_en && $stable(wr))[*4] |-> internal_ref_enable == wr;
  endproperty
  a_ref: assert property (p_ref) else $error("reference ignores pin");
  property p_ref_hold; (hw_sw_select && clk_en)[*4] |=> $stable(internal_ref_enable); endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference moved in write mode");
  property p_chain;
    (clk_en && $stable({ser, ln[7]}))[*4] |-> chain_mode_enable == (ser && ln[7]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain enable wrong");
  c_conv: cover property ($rose(busy));
  c_read: cover property ($rose(oe[0]));
  c_frame: cover property (ser && !cs_n && serial_data_oe[2]);
endmodule // adc_host_checker

bind adc_host_interface_select adc_host_checker u_chk (.pclk, .presetn, .clk_en, .cs_n, .rd_n,
  .write_or_ref_control_pin, .hw_sw_select, .serial_parallel_select, .pair_sample_start,
  .parallel_data_line_in, .parallel_data_line_oe, .serial_data_oe, .busy, .internal_ref_enable,
  .chain_mode_enable);

`default_nettype wire

// >>> verification/host_model.sv
`timescale 1ns/10ps
`default_nettype none

// host side of the pins; serial clock runs only inside a frame
module host_model (
  input  wire logic        pclk,
  input  wire logic [15:0] line,
  output var  logic        cs_n,
  output var  logic        rd_n,
  output var  logic        wr_ref,
  output var  logic        hw_sw,
  output var  logic        ser_par,
  output var  logic [2:0]  start,
  output var  logic        sclk,
  output var  logic        drv_en,
  output var  logic [15:0] drv
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_ref = 1'b1;
    hw_sw = 1'b1;
    ser_par = 1'b0;
    start = 3'b000;
    sclk = 1'b0;
    drv_en = 1'b0;
    drv = 16'h0000;
  end
  ////////////////////////////////////////
  task automatic par_read(output logic [15:0] d);
    @(posedge pclk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (5) @(posedge pclk);
    d = line;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask

  task automatic ctrl_write(input logic [7:0] b);
    @(posedge pclk);
    drv_en <= 1'b1;
    drv <= {b, 8'h00};
    @(posedge pclk);
    cs_n <= 1'b0;
    wr_ref <= 1'b0;
    repeat (5) @(posedge pclk);
    cs_n <= 1'b1;
    wr_ref <= 1'b1;
    // byte kept on the bus past the strobe; the commit takes the byte sampled while the strobe was low
    repeat (4) @(posedge pclk);
    drv_en <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic frame(input logic [2:0] sel, input int n, output logic [2:0][95:0] got);
    got = '0;
    @(posedge pclk);
    rd_n <= 1'b0;
    drv_en <= 1'b1;
    drv <= {13'h0000, sel | 3'b001};
    repeat (4) @(posedge pclk);
    cs_n <= 1'b0;
    @(posedge pclk);
    for (int k = 0; k < n; k++) begin
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
      for (int l = 0; l < 3; l++) got[l][n-1-k] = line[8+l];
    end
    @(posedge pclk);
    cs_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
endmodule // host_model

`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam logic [95:0] BANK = 96'ha5c3_0f1e_8001_7ffe_3c5a_ffff;
  logic              pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, busy, ref_en, chain, e;
  logic              cs_n, rd_n, wr_ref, hw_sw, ser_par, sclk, drv_en;
  logic [2:0]        start, sout, soe;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, r;
  logic [15:0]       line_in, pout, poe, drv, d, smask, hmask;
  logic [15:0]       last = 16'h0000;
  logic [2:0][95:0]  got;
  int                failures = 0;
  int                num_checks = 0;
  int                n;

  adc_host_interface_select uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .serial_clk(sclk), .cs_n, .rd_n, .write_or_ref_control_pin(wr_ref),
    .hw_sw_select(hw_sw), .serial_parallel_select(ser_par), .pair_sample_start(start),
    .parallel_data_line_in(line_in), .parallel_data_line_out(pout), .parallel_data_line_oe(poe),
    .serial_data_out(sout), .serial_data_oe(soe), .busy, .internal_ref_enable(ref_en),
    .chain_mode_enable(chain));
  host_model host (.pclk, .line(line_in), .cs_n, .rd_n, .wr_ref, .hw_sw, .ser_par, .start, .sclk,
    .drv_en, .drv);

  // released lines show the inverse of their last level, never a settled guess
  assign smask = {5'h00, soe, 8'h00};
  assign hmask = drv_en ? (ser_par ? 16'hf8ff : 16'hffff) : 16'h0000;
  assign line_in = (poe & pout) | (~poe & smask & {5'h00, sout, 8'h00})
                 | (~poe & ~smask & hmask & drv) | (~poe & ~smask & ~hmask & ~last);
  always @(posedge pclk) last <= line_in;
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_busy(input logic lvl);
    n = 0;
    while (busy !== lvl && n < 400) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic final_report;
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    final_report();
  end

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("ref_rst", ref_en, 1'b1);
    check("oe_rst", poe, 16'h0000);
    repeat (3) @(posedge pclk);
    apb(1'b0, adc_host_pkg::OFF_STATUS, 32'h0000_0000);
    check("status_rst", r, 32'h0000_000c);
    apb(1'b0, adc_host_pkg::OFF_CONV_TIME, 32'h0000_0000);
    check("conv_rst", r, {16'h0000, adc_host_pkg::CONV_TIME_RESET});
    apb(1'b0, adc_host_pkg::OFF_RESULT5, 32'h0000_0000);
    check("res_rst", r, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    check("unmapped", {e, r}, {1'b1, 32'h0000_0000});
    apb(1'b1, adc_host_pkg::OFF_CONV_TIME, 32'h0000_0005);
    for (int i = 0; i < 6; i++) apb(1'b1, adc_host_pkg::OFF_RESULT0 + 8'(4 * i), {16'h0000, BANK[95-16*i -: 16]});
    host.start <= 3'b111;
    wait_busy(1'b1);
    host.start <= 3'b000;
    wait_busy(1'b0);
    check("busy_len", n, 5);
    for (int i = 0; i < 7; i++) begin
      host.par_read(d);
      check("par_word", d, BANK[95-16*(i%6) -: 16]);
    end
    check("par_idle", poe, 16'h0000);
    host.ctrl_write(8'h5a);
    apb(1'b0, adc_host_pkg::OFF_STATUS, 32'h0000_0000);
    check("ctrl_byte", r[15:8], 8'h5a);
    check("ref_held", ref_en, 1'b1);
    host.hw_sw <= 1'b0;
    repeat (6) @(posedge pclk);
    clk_en <= 1'b0;
    host.wr_ref <= 1'b0;
    repeat (6) @(posedge pclk);
    check("ref_frozen", ref_en, 1'b1);
    clk_en <= 1'b1;
    repeat (6) @(posedge pclk);
    check("ref_off", ref_en, 1'b0);
    host.wr_ref <= 1'b1;
    repeat (6) @(posedge pclk);
    check("ref_on", ref_en, 1'b1);
    host.ctrl_write(8'hc3);
    apb(1'b0, adc_host_pkg::OFF_STATUS, 32'h0000_0000);
    check("ctrl_kept", r[15:8], 8'h5a);
    host.drv_en <= 1'b1;
    host.drv <= 16'h0081;
    host.ser_par <= 1'b1;
    host.rd_n <= 1'b0;
    repeat (6) @(posedge pclk);
    check("chain_on", chain, 1'b1);
    check("ser_no_par", poe, 16'h0000);
    for (int m = 1; m <= 3; m++) begin
      host.frame(3'((1 << m) - 1), 96 / m, got);
      for (int l = 0; l < m; l++) check("ser_word", got[l], (BANK >> (96 - (l + 1) * (96 / m))) & ((96'h1 << (96 / m)) - 1));
    end
    check("chain_off", chain, 1'b0);
    final_report();
  end
endmodule // tb

`default_nettype wire
